// >>> dv/mmx_exec_properties.sv
// Port assertions for the move and multiply executor
`timescale 1ns/1ps
module mmx_exec_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] mem_rdata,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic [1:0] quarter,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] accum,
  input wire logic [7:0] bank_select_reg,
  input wire logic [7:0] product_high_byte,
  input wire logic [7:0] product_low_byte,
  input wire logic status_write
);
  // ****
  // Word tracking
  // ****
  logic move_open;
  wire take = quarter == 2'h3 && instr_valid && instr_ready;
  wire op_take = take && !move_open;
  wire [3:0] pre = instr_word[15:12];
  wire [11:0] addr = instr_word[11:0];
  wire [7:0] lit = instr_word[7:0];
  wire [15:0] mul_exp = {8'h00, accum} * {8'h00, lit};
  wire [11:0] st_addr = {instr_word[8] ? bank_select_reg[3:0] : {4{lit[7]}}, lit};
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      move_open <= 1'b0;
    end else if (take) begin
      move_open <= pre == 4'hC;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Properties
  // ****
  property p_no_flags;
    !status_write;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("flag write");
  property p_acc;
    op_take && instr_word[15:8] == 8'h0E |=> accum == $past(lit) && instr_done;
  endproperty
  a_acc: assert property (p_acc) else $error("accum load");
  property p_bank;
    op_take && instr_word[15:8] == 8'h01 |=> bank_select_reg == $past(lit);
  endproperty
  a_bank: assert property (p_bank) else $error("bank load");
  property p_mul;
    op_take && instr_word[15:8] == 8'h0D |=>
      {product_high_byte, product_low_byte} == $past(mul_exp) && accum == $past(accum);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply");
  property p_store;
    op_take && instr_word[15:9] == 7'h37 |=>
      mem_wr && mem_wdata == $past(accum) && mem_addr == $past(st_addr);
  endproperty
  a_store: assert property (p_store) else $error("store");
  property p_move_rd;
    op_take && pre == 4'hC && addr != 12'hFE8 |-> ##3 mem_rd && mem_addr == $past(addr, 3);
  endproperty
  a_move_rd: assert property (p_move_rd) else $error("move read");
  property p_move_wr;
    take && move_open && pre == 4'hF && addr != 12'hFE8 |->
      ##4 mem_wr && instr_done && mem_addr == $past(addr, 4);
  endproperty
  a_move_wr: assert property (p_move_wr) else $error("move write");
  property p_lone;
    op_take && pre == 4'hF |=> (!mem_wr && !mem_rd) [*4];
  endproperty
  a_lone: assert property (p_lone) else $error("lone word");
  property p_ready;
    instr_ready == (quarter == 2'h3);
  endproperty
  a_ready: assert property (p_ready) else $error("ready quarter");
endmodule // mmx_exec_properties
bind mmx_exec mmx_exec_properties props_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .instr_word(instr_word), .mem_rdata(mem_rdata),
  .instr_ready(instr_ready), .instr_done(instr_done), .quarter(quarter), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .accum(accum),
  .bank_select_reg(bank_select_reg), .product_high_byte(product_high_byte),
  .product_low_byte(product_low_byte), .status_write(status_write));

// >>> dv/mmx_mem_model.sv
// Data memory seen by the executor
`timescale 1ns/1ps
module mmx_mem_model (
  input wire logic ref_clk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      last <= mem[mem_addr];
    end
  end
  // Idle bus inverted so stale bytes never pass as reads
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
endmodule // mmx_mem_model

// >>> dv/testbench.sv
// Self-checking testbench for the move and multiply executor
`timescale 1ns/1ps
module testbench;
  logic ref_clk, sys_rst, instr_valid, instr_ready, instr_done, mem_rd, mem_wr, status_write;
  logic [15:0] instr_word;
  logic [11:0] mem_addr;
  logic [7:0] mem_rdata, mem_wdata, accum, bank_select_reg, product_high_byte, product_low_byte;
  logic [1:0] quarter;
  int err_total = 0;
  int checked = 0;
  mmx_exec dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .mem_rdata(mem_rdata), .instr_ready(instr_ready),
    .instr_done(instr_done), .quarter(quarter), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .accum(accum),
    .bank_select_reg(bank_select_reg), .product_high_byte(product_high_byte),
    .product_low_byte(product_low_byte), .status_write(status_write));
  mmx_mem_model mem_u (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic issue(input logic [15:0] w);
    @(negedge ref_clk);
    while (quarter !== 2'h3) @(negedge ref_clk);
    check("ready", 16'h0001, {15'h0000, instr_ready});
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask
  // Extra edge lets the memory write land before checks
  task automatic finish_op(input string name);
    int n = 0;
    while (instr_done !== 1'b1 && n < 12) begin
      @(negedge ref_clk);
      n++;
    end
    check(name, 16'h0001, {15'h0000, instr_done});
    check("status_write", 16'h0000, {15'h0000, status_write});
    @(negedge ref_clk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_loads;
    check("accum_rst", 16'h0000, {8'h00, accum});
    check("quarter_rst", 16'h0000, {14'h0000, quarter});
    issue(16'h0E5A);
    finish_op("acc_done");
    check("accum", 16'h005A, {8'h00, accum});
    issue(16'h01A5);
    finish_op("bank_done");
    check("bank", 16'h00A5, {8'h00, bank_select_reg});
  endtask
  task automatic t_mul;
    logic [7:0] a [3] = '{8'hFF, 8'hC4, 8'h00};
    logic [7:0] k [3] = '{8'hFF, 8'hE2, 8'h37};
    for (int i = 0; i < 3; i++) begin
      issue({8'h0E, a[i]});
      issue({8'h0D, k[i]});
      finish_op("mul_done");
      check("product", {8'h00, a[i]} * {8'h00, k[i]}, {product_high_byte, product_low_byte});
      check("accum_kept", {8'h00, a[i]}, {8'h00, accum});
    end
  endtask
  task automatic t_store;
    issue(16'h0E4F);
    issue(16'h0105);
    issue(16'h6E20);
    issue(16'h6E90);
    issue(16'h6F33);
    finish_op("store_done");
    check("store_low", 16'h004F, {8'h00, mem_u.mem[12'h020]});
    check("store_high", 16'h004F, {8'h00, mem_u.mem[12'hF90]});
    check("store_bank", 16'h004F, {8'h00, mem_u.mem[12'h533]});
  endtask
  task automatic t_move;
    mem_u.mem[12'h000] = 8'h3C;
    issue(16'hC000);
    issue(16'hFFFF);
    finish_op("move_done");
    check("move_top", 16'h003C, {8'h00, mem_u.mem[12'hFFF]});
    issue(16'hC000);
    issue(16'hFFE8);
    finish_op("move_acc_done");
    check("move_to_acc", 16'h003C, {8'h00, accum});
    issue(16'h0E77);
    issue(16'hCFE8);
    issue(16'hF123);
    finish_op("move_from_acc_done");
    check("move_from_acc", 16'h0077, {8'h00, mem_u.mem[12'h123]});
    issue(16'hF456);
    finish_op("lone_done");
    check("lone_mem", 16'h0000, {8'h00, mem_u.mem[12'h456]});
    check("lone_acc", 16'h0077, {8'h00, accum});
  endtask
  task automatic summarize;
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #40000;
    err_total++;
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_loads();
    t_mul();
    t_store();
    t_move();
    summarize();
  end
endmodule // testbench

// >>> inc/mmx_pkg.sv
// Types shared by the move and multiply executor
package mmx_pkg;
  typedef enum logic [1:0] {
    MMX_IDLE,
    MMX_MOVE_READ,
    MMX_MOVE_WRITE
  } mmx_state_t;
endpackage

// >>> inc/mmx_regs.svh
// Encodings, field positions, reset values and timing counts of the move and multiply executor
`ifndef MMX_REGS_SVH
`define MMX_REGS_SVH

// ******************************************************************
// Opcode patterns
// ******************************************************************
`define MMX_OP_MOVE_SRC 4'hC
`define MMX_OP_MOVE_DST 4'hF
`define MMX_OP_BANK_LIT 8'h01
`define MMX_OP_ACC_LIT 8'h0E
`define MMX_OP_MUL_LIT 8'h0D
`define MMX_OP_STORE 7'h37

// ******************************************************************
// Field positions
// ******************************************************************
`define MMX_ADDR_MSB 11
`define MMX_LIT_MSB 7
`define MMX_ACCESS_BIT 8

// ******************************************************************
// Data space
// ******************************************************************
`define MMX_ACCUM_ADDR 12'hFE8
`define MMX_ACCESS_SPLIT 8'h80
`define MMX_ACCESS_HIGH_BANK 4'hF
`define MMX_ACCESS_LOW_BANK 4'h0

// ******************************************************************
// Reset values and timing
// ******************************************************************
`define MMX_ACCUM_RST 8'h00
`define MMX_BANK_RST 8'h00
`define MMX_PROD_RST 8'h00
`define MMX_QUARTERS 2'h3
`define MMX_Q_READ 2'h1
`define MMX_Q_WRITE 2'h2
`define MMX_SCRATCH_RST 8'h00

`endif

// >>> src/mmx_exec.sv
// Decode and execute of the move, literal load, store and literal multiply group
// Functional notes
// - Register move spans two words: source address then destination address, 0..4095.
// - Register move copies source byte to destination; status flags untouched.
// - Move addresses reach full 12-bit data space without bank select.
// - Accumulator is addressable as move source or destination.
// - Move takes two cycles; read in first, write in last quarter of second.
// - Bank literal load writes literal into bank select register, one cycle.
// - Accumulator literal load places literal in accumulator, one cycle, no flags.
// - Store copies accumulator to addressed file register, one cycle, no flags.
// - Store's 8-bit address picks a location in a 256-byte bank.
// - Access bit 0 uses access bank; 1 uses bank select register.
// - Literal multiply forms unsigned 16-bit product of accumulator and literal.
// - Product high gets upper byte, low gets lower; accumulator unchanged.
// - Literal multiply leaves every status flag untouched.
`timescale 1ns/1ps
`include "mmx_regs.svh"
module mmx_exec (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] mem_rdata,
  output logic instr_ready,
  output logic instr_done,
  output logic [1:0] quarter,
  output logic mem_rd,
  output logic mem_wr,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic [7:0] accum,
  output logic [7:0] bank_select_reg,
  output logic [7:0] product_high_byte,
  output logic [7:0] product_low_byte,
  output logic status_write
);
  // ******************************************************************
  // Quarter phase counter
  // ******************************************************************
  logic [1:0] next_quarter;
  always_comb begin
    next_quarter = quarter + 2'h1;
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quarter <= 2'h0;
    end else begin
      quarter <= next_quarter;
    end
  end

  // ******************************************************************
  // Decode
  // ******************************************************************
  logic q_last;
  logic is_move_src;
  logic is_move_dst;
  logic is_bank_lit;
  logic is_acc_lit;
  logic is_mul_lit;
  logic is_store;
  logic [7:0] lit;
  logic [11:0] store_addr;
  logic [15:0] mul_product;
  assign q_last = (quarter == `MMX_QUARTERS);
  assign lit = instr_word[`MMX_LIT_MSB:0];
  assign is_move_src = (instr_word[15:12] == `MMX_OP_MOVE_SRC);
  assign is_move_dst = (instr_word[15:12] == `MMX_OP_MOVE_DST);
  assign is_bank_lit = (instr_word[15:8] == `MMX_OP_BANK_LIT);
  assign is_acc_lit = (instr_word[15:8] == `MMX_OP_ACC_LIT);
  assign is_mul_lit = (instr_word[15:8] == `MMX_OP_MUL_LIT);
  assign is_store = (instr_word[15:9] == `MMX_OP_STORE);

  // Access bank: low half maps to bank 0, high half to the special registers
  always_comb begin
    if (!instr_word[`MMX_ACCESS_BIT]) begin
      if (lit < `MMX_ACCESS_SPLIT) begin
        store_addr = {`MMX_ACCESS_LOW_BANK, lit};
      end else begin
        store_addr = {`MMX_ACCESS_HIGH_BANK, lit};
      end
    end else begin
      store_addr = {bank_select_reg[3:0], lit};
    end
  end

  mmx_mul8 u_mul (
    .op_a(accum),
    .op_b(lit),
    .product(mul_product)
  );

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  mmx_pkg::mmx_state_t state;
  mmx_pkg::mmx_state_t next_state;
  logic next_ready;
  logic next_done;
  logic take_word;
  logic op_take;
  logic move_first;
  logic move_second;
  logic read_launch;
  logic write_launch;
  logic src_is_accum;
  logic dst_is_accum;
  logic [11:0] src_addr;
  logic [11:0] dst_addr;

  assign take_word = instr_valid && q_last;
  assign op_take = (state == mmx_pkg::MMX_IDLE) && take_word;
  assign move_first = op_take && is_move_src;
  assign move_second = (state == mmx_pkg::MMX_MOVE_READ) && take_word;
  assign read_launch = (state == mmx_pkg::MMX_MOVE_READ) && (quarter == `MMX_Q_READ);
  assign write_launch = (state == mmx_pkg::MMX_MOVE_WRITE) && (quarter == `MMX_Q_WRITE);
  assign src_is_accum = (src_addr == `MMX_ACCUM_ADDR);
  assign dst_is_accum = (dst_addr == `MMX_ACCUM_ADDR);

  // Limitation: the three-cycle extended form of the move is not modelled
  always_comb begin
    next_state = state;
    next_done = 1'b0;
    case (state)
      mmx_pkg::MMX_IDLE: begin
        // Words are taken only at the end of a cycle, in the last quarter
        if (move_first) begin
          next_state = mmx_pkg::MMX_MOVE_READ;
        end else if (op_take) begin
          // Unknown words and a stray destination word end as a no-operation
          next_done = 1'b1;
        end
      end
      mmx_pkg::MMX_MOVE_READ: begin
        // Source is fetched again each cycle until the second word arrives
        if (move_second) begin
          next_state = mmx_pkg::MMX_MOVE_WRITE;
        end
      end
      mmx_pkg::MMX_MOVE_WRITE: begin
        // No dummy read in the second cycle; write only in its last quarter
        if (write_launch) begin
          next_done = 1'b1;
          next_state = mmx_pkg::MMX_IDLE;
        end
      end
      default: begin
        next_state = mmx_pkg::MMX_IDLE;
      end
    endcase
    // Also covers the last quarter of a move write cycle, when idle again
    next_ready = (next_state != mmx_pkg::MMX_MOVE_WRITE) && (next_quarter == `MMX_QUARTERS);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= mmx_pkg::MMX_IDLE;
      instr_ready <= 1'b0;
      instr_done <= 1'b0;
      status_write <= 1'b0;
    end else begin
      state <= next_state;
      instr_ready <= next_ready;
      instr_done <= next_done;
      // None of this group touches status flags
      status_write <= 1'b0;
    end
  end

  // ******************************************************************
  // Move operands
  // ******************************************************************
  logic [7:0] move_data;
  logic [7:0] next_move_data;
  logic [11:0] next_src_addr;
  logic [11:0] next_dst_addr;

  always_comb begin
    next_move_data = move_data;
    next_src_addr = src_addr;
    next_dst_addr = dst_addr;
    if (move_first) begin
      next_src_addr = instr_word[`MMX_ADDR_MSB:0];
    end
    if (move_second) begin
      next_dst_addr = instr_word[`MMX_ADDR_MSB:0];
    end
    // The accumulator has no memory cell behind it, so it is read here
    if (read_launch && src_is_accum) begin
      next_move_data = accum;
    end
    // Memory data stands only in the quarter in which the read strobe is high
    if (mem_rd) begin
      next_move_data = mem_rdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      move_data <= `MMX_SCRATCH_RST;
      src_addr <= 12'h000;
      dst_addr <= 12'h000;
    end else begin
      move_data <= next_move_data;
      src_addr <= next_src_addr;
      dst_addr <= next_dst_addr;
    end
  end

  // ******************************************************************
  // Architectural registers
  // ******************************************************************
  logic [7:0] next_accum;
  logic [7:0] next_bank;
  logic [7:0] next_prod_hi;
  logic [7:0] next_prod_lo;

  always_comb begin
    next_accum = accum;
    next_bank = bank_select_reg;
    next_prod_hi = product_high_byte;
    next_prod_lo = product_low_byte;
    if (op_take) begin
      if (is_bank_lit) begin
        // All eight bits are kept; only the low nibble picks a bank
        next_bank = lit;
      end else if (is_acc_lit) begin
        next_accum = lit;
      end else if (is_mul_lit) begin
        // Accumulator is only an operand and keeps its value
        next_prod_hi = mul_product[15:8];
        next_prod_lo = mul_product[7:0];
      end
    end
    if (write_launch && dst_is_accum) begin
      next_accum = move_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accum <= `MMX_ACCUM_RST;
      bank_select_reg <= `MMX_BANK_RST;
      product_high_byte <= `MMX_PROD_RST;
      product_low_byte <= `MMX_PROD_RST;
    end else begin
      accum <= next_accum;
      bank_select_reg <= next_bank;
      product_high_byte <= next_prod_hi;
      product_low_byte <= next_prod_lo;
    end
  end

  // ******************************************************************
  // Data memory port
  // ******************************************************************
  logic next_rd;
  logic next_wr;
  logic [11:0] next_addr;
  logic [7:0] next_wdata;

  // A store is taken only when idle, so it never meets a move on these lines
  always_comb begin
    next_rd = 1'b0;
    next_wr = 1'b0;
    next_addr = mem_addr;
    next_wdata = mem_wdata;
    if (op_take && is_store) begin
      next_addr = store_addr;
      next_wdata = accum;
      next_wr = 1'b1;
    end
    if (read_launch && !src_is_accum) begin
      next_rd = 1'b1;
      next_addr = src_addr;
    end
    if (write_launch && !dst_is_accum) begin
      next_wr = 1'b1;
      next_addr = dst_addr;
      next_wdata = move_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 12'h000;
      mem_wdata <= 8'h00;
    end else begin
      mem_rd <= next_rd;
      mem_wr <= next_wr;
      mem_addr <= next_addr;
      mem_wdata <= next_wdata;
    end
  end
endmodule // mmx_exec

// >>> src/mmx_mul8.sv
// Unsigned 8 by 8 multiplier, single cycle
`timescale 1ns/1ps
module mmx_mul8 (
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  output logic [15:0] product
);
  // ******************************************************************
  // Shift and add array
  // ******************************************************************
  logic [15:0] partial [0:8];
  assign partial[0] = 16'h0000;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_row
      assign partial[i+1] = partial[i] + (op_b[i] ? ({8'h00, op_a} << i) : 16'h0000);
    end
  endgenerate
  // Full width, so neither carry nor overflow can occur
  assign product = partial[8];
endmodule // mmx_mul8
